// *** hw/mcl_defs.svh ***
// offsets, field positions, reset values and timing figures of the supervisor
`ifndef MCL_DEFS_SVH
`define MCL_DEFS_SVH
`define MCL_OFF_CFG 8'h00
`define MCL_OFF_MOT 8'h04
`define MCL_OFF_FLT 8'h08
`define MCL_OFF_STS 8'h0C
`define MCL_CFG_RESET 32'h00003F00
`define MCL_MOT_RESET 32'h00000000
`define MCL_CFG_ACC_LSB 0
`define MCL_CFG_LCK_LSB 4
`define MCL_CFG_EN_LSB 8
`define MCL_MOT_RM_LSB 0
`define MCL_MOT_KT_LSB 8
`define MCL_FLT_OC_BIT 6
`define MCL_STS_AMP_LSB 16
`define MCL_ACC_STEP_MA 12'h0C8
`define MCL_LCK_STEP_MA 12'h1F4
`define MCL_NO_MOTOR_MA 12'h08C
`define MCL_BRAKE_FLOOR_MA 12'h064
`define MCL_ULIM_SHIFT 10
`define MCL_KTC_SHIFT 12
`define MCL_CLK_KHZ 200000
`define MCL_LOCK_OFF_MS 5000
`define MCL_ERR_WIN_MS 100
`define MCL_KT_WIN_MS 100
`define MCL_BRAKE_US 100
`endif

// *** hw/mcl_persist.sv ***
// condition persistence timer: hit rises once cond has held limit cycles
`timescale 1ns/1ps
module mcl_persist #(
	parameter int W = 32
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// condition
	input wire logic cond,
	input wire logic [W-1:0] limit,
	output logic hit
);
	logic [W-1:0] cnt;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= '0;
			hit <= 1'b0;
		end else if (ce) begin
			if (!cond) begin
				cnt <= '0;
				hit <= 1'b0;
			end else if (cnt >= limit - W'(1)) begin
				hit <= 1'b1;
			end else begin
				cnt <= cnt + W'(1);
			end
		end
	end
endmodule

// *** hw/mcl_pkg.sv ***
// types shared by the supervisor files
package mcl_pkg;
	typedef enum logic [2:0] {
		MCL_RUN = 3'h1,
		MCL_BRAKE = 3'h2,
		MCL_OFF = 3'h4
	} mcl_state_t;
	typedef struct packed {
		logic [11:0] lowside_ma;
		logic [11:0] phase_u_ma;
		logic [15:0] speed;
		logic [15:0] amp_cmd;
	} mcl_meas_t;
	typedef struct packed {
		logic zero_cross;
		logic commutate;
		logic elec_cycle;
		logic ol_to_cl;
		logic closed_loop;
		logic open_loop;
		logic above_handoff;
	} mcl_events_t;
endpackage

// *** hw/mcl_supervisor.sv ***
// current limit and lock detection supervisor with axi4-lite registers
`timescale 1ns/1ps
`include "mcl_defs.svh"
module mcl_supervisor #(
	parameter int LOCK_OFF_CYCLES = `MCL_LOCK_OFF_MS * `MCL_CLK_KHZ,
	parameter int ERR_WIN_CYCLES = `MCL_ERR_WIN_MS * `MCL_CLK_KHZ,
	parameter int KT_WIN_CYCLES = `MCL_KT_WIN_MS * `MCL_CLK_KHZ,
	parameter int BRAKE_CYCLES = `MCL_BRAKE_US * `MCL_CLK_KHZ / 1000
) (
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// motor control side
	input wire mcl_pkg::mcl_meas_t meas,
	input wire mcl_pkg::mcl_events_t ev,
	input wire logic fg_in,
	input wire logic short_pin,
	// bridge side
	output logic [15:0] amp_out,
	output logic bridge_hiz,
	output logic lowside_all_on,
	output logic restart,
	output logic speed_feedback_output
);
	mcl_pkg::mcl_state_t state;
	logic [31:0] cfg, mot;
	logic [5:0] fault_flags;
	logic oc_flag;
	logic [1:0] short_sync;
	logic [31:0] off_cnt;
	logic aw_held, w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [5:0] detect;
	logic trip, oc_now;
	logic [3:0] accel_current_threshold;
	logic [2:0] lock_current_threshold;
	logic [5:0] detect_scheme_enables;
	logic [6:0] phase_resistance_setting, bemf_constant_setting;
	logic [10:0] rm_val, kt_val;
	logic [11:0] acc_ma, lck_ma;
	logic [27:0] ulimit;
	logic [26:0] bemf_spd_full;
	logic [15:0] bemf_spd, bemf_cur, iu_drop;
	logic [31:0] half_acc;
	logic [19:0] ktc;
	logic ktc_valid;
	logic [31:0] comm_cnt, prev_period;
	logic prev_valid;
	logic ol_armed, ol_seen;
	logic flag_abnormal_speed_hit, flag_abnormal_constant_hit, brake_done;

	assign accel_current_threshold = cfg[`MCL_CFG_ACC_LSB +: 4];
	assign lock_current_threshold = cfg[`MCL_CFG_LCK_LSB +: 3];
	assign detect_scheme_enables = cfg[`MCL_CFG_EN_LSB +: 6];
	assign phase_resistance_setting = mot[`MCL_MOT_RM_LSB +: 7];
	assign bemf_constant_setting = mot[`MCL_MOT_KT_LSB +: 7];

	// exponent and mantissa settings and current threshold steps to linear values
	assign rm_val = 11'({7'h00, phase_resistance_setting[3:0]} << phase_resistance_setting[6:4]);
	assign kt_val = 11'({7'h00, bemf_constant_setting[3:0]} << bemf_constant_setting[6:4]);
	assign acc_ma = 12'(({8'h00, accel_current_threshold} + 12'h001) * `MCL_ACC_STEP_MA);
	assign lck_ma = 12'(({9'h000, lock_current_threshold} + 12'h001) * `MCL_LCK_STEP_MA);

	// voltage cap from programmed motor model, no current measured
	assign ulimit = 28'((23'(acc_ma) * 23'(rm_val)) >> `MCL_ULIM_SHIFT)
		+ 28'((27'(meas.speed) * 27'(kt_val)) >> `MCL_ULIM_SHIFT);
	assign bemf_spd_full = 27'((27'(meas.speed) * 27'(kt_val)) >> `MCL_ULIM_SHIFT);
	assign bemf_spd = (|bemf_spd_full[26:16]) ? 16'hFFFF : bemf_spd_full[15:0];
	assign iu_drop = 16'((23'(meas.phase_u_ma) * 23'(rm_val)) >> `MCL_ULIM_SHIFT);
	assign bemf_cur = (amp_out > iu_drop) ? amp_out - iu_drop : 16'h0000;

	// drive amplitude clamp, closed loop only, zero outside run state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			amp_out <= 16'h0000;
		end else if (ce) begin
			if (state != mcl_pkg::MCL_RUN) begin
				amp_out <= 16'h0000;
			end else if (ev.closed_loop && (28'(meas.amp_cmd) > ulimit)) begin
				amp_out <= ulimit[15:0];
			end else begin
				amp_out <= meas.amp_cmd;
			end
		end
	end

	// short circuit pin synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			short_sync <= 2'h0;
		end else if (ce) begin
			short_sync <= {short_sync[0], short_pin};
		end
	end
	assign oc_now = short_sync[1];

	// bemf integration over each half electrical cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			half_acc <= 32'h0;
			ktc <= 20'h0;
			ktc_valid <= 1'b0;
		end else if (ce) begin
			if (restart) begin
				half_acc <= 32'h0;
				ktc_valid <= 1'b0;
			end else if (ev.zero_cross) begin
				ktc <= half_acc[`MCL_KTC_SHIFT +: 20];
				ktc_valid <= ev.closed_loop;
				half_acc <= 32'(bemf_cur);
			end else begin
				half_acc <= half_acc + 32'(bemf_cur);
			end
		end
	end

	// bemf far above amplitude for the error window
	mcl_persist #(.W(32)) u_speed_err (
		.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.cond(ev.closed_loop && ({1'b0, bemf_spd} > 17'(amp_out) + 17'(amp_out >> 1))),
		.limit(32'(ERR_WIN_CYCLES)), .hit(flag_abnormal_speed_hit)
	);
	// measured constant outside half to one and a half of programmed
	mcl_persist #(.W(32)) u_kt_err (
		.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.cond(ktc_valid && ((ktc < 20'(kt_val - (kt_val >> 1)))
			|| (ktc > 20'(kt_val + (kt_val >> 1))))),
		.limit(32'(KT_WIN_CYCLES)), .hit(flag_abnormal_constant_hit)
	);
	// brake current under floor for the brake time
	mcl_persist #(.W(32)) u_brake (
		.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.cond((state == mcl_pkg::MCL_BRAKE) && (meas.phase_u_ma < `MCL_BRAKE_FLOOR_MA)),
		.limit(32'(BRAKE_CYCLES)), .hit(brake_done)
	);

	// open loop: one electrical cycle past handoff rate with no bemf
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ol_armed <= 1'b0;
			ol_seen <= 1'b0;
		end else if (ce) begin
			if (!ev.open_loop || !ev.above_handoff || restart) begin
				ol_armed <= 1'b0;
				ol_seen <= 1'b0;
			end else if (ev.elec_cycle) begin
				ol_armed <= 1'b1;
				ol_seen <= 1'b0;
			end else if (ev.zero_cross) begin
				ol_seen <= 1'b1;
			end
		end
	end

	// commutation period tracking
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			comm_cnt <= 32'h0;
			prev_period <= 32'h0;
			prev_valid <= 1'b0;
		end else if (ce) begin
			if (!ev.closed_loop || restart) begin
				comm_cnt <= 32'h0;
				prev_valid <= 1'b0;
			end else if (ev.commutate) begin
				prev_period <= comm_cnt;
				prev_valid <= 1'b1;
				comm_cnt <= 32'h0;
			end else if (comm_cnt != 32'hFFFFFFFF) begin
				comm_cnt <= comm_cnt + 32'h1;
			end
		end
	end

	// raw detections, scheme order bit 0 to 5
	always_comb begin
		detect[0] = meas.lowside_ma > lck_ma;
		detect[1] = flag_abnormal_speed_hit;
		detect[2] = flag_abnormal_constant_hit;
		detect[3] = ev.ol_to_cl && (meas.phase_u_ma <= `MCL_NO_MOTOR_MA);
		detect[4] = ol_armed && ev.elec_cycle && !ol_seen;
		detect[5] = ev.closed_loop && prev_valid && ({1'b0, comm_cnt} > {prev_period, 1'b0});
	end
	// enabled schemes trip, overcurrent always trips
	assign trip = (state == mcl_pkg::MCL_RUN) && ((|(detect & detect_scheme_enables)) || oc_now);

	// fault flags: set even when disabled, cleared at restart, set wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_flags <= 6'h00;
			oc_flag <= 1'b0;
		end else if (ce) begin
			fault_flags <= (restart ? 6'h00 : fault_flags) | detect;
			oc_flag <= (restart ? 1'b0 : oc_flag) | oc_now;
		end
	end

	// run, brake, off sequence with lock-off retry
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= mcl_pkg::MCL_RUN;
			off_cnt <= 32'h0;
			restart <= 1'b0;
		end else if (ce) begin
			restart <= 1'b0;
			case (state)
				mcl_pkg::MCL_RUN: begin
					off_cnt <= 32'h0;
					if (trip) begin
						state <= mcl_pkg::MCL_BRAKE;
					end
				end
				mcl_pkg::MCL_BRAKE: begin
					if (brake_done) begin
						state <= mcl_pkg::MCL_OFF;
					end
				end
				mcl_pkg::MCL_OFF: begin
					if (off_cnt >= 32'(LOCK_OFF_CYCLES) - 32'h1) begin
						state <= mcl_pkg::MCL_RUN;
						restart <= 1'b1;
					end else begin
						off_cnt <= off_cnt + 32'h1;
					end
				end
				default: begin
					state <= mcl_pkg::MCL_RUN;
				end
			endcase
		end
	end

	// bridge and speed feedback outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bridge_hiz <= 1'b0;
			lowside_all_on <= 1'b0;
			speed_feedback_output <= 1'b0;
		end else if (ce) begin
			bridge_hiz <= (state == mcl_pkg::MCL_OFF) || (state == mcl_pkg::MCL_BRAKE && brake_done);
			lowside_all_on <= (state == mcl_pkg::MCL_BRAKE && !brake_done) || (state == mcl_pkg::MCL_RUN && trip);
			speed_feedback_output <= (state != mcl_pkg::MCL_RUN) || trip || fg_in;
		end
	end

	// axi4-lite write: address and data held in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			cfg <= `MCL_CFG_RESET;
			mot <= `MCL_MOT_RESET;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (aw_held && w_held && !s_axi_bvalid) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
				for (int i = 0; i < 4; i++) begin
					if (w_strb[i] && aw_addr == `MCL_OFF_CFG) begin
						cfg[i*8 +: 8] <= w_data[i*8 +: 8];
					end
					if (w_strb[i] && aw_addr == `MCL_OFF_MOT) begin
						mot[i*8 +: 8] <= w_data[i*8 +: 8];
					end
				end
				if (aw_addr != `MCL_OFF_CFG && aw_addr != `MCL_OFF_MOT) begin
					s_axi_bresp <= 2'h2;
				end
			end
		end
	end
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;

	// axi4-lite read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else if (ce) begin
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end else if (s_axi_arvalid && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				case (s_axi_araddr)
					`MCL_OFF_CFG: s_axi_rdata <= {18'h0, cfg[13:8], 1'b0, cfg[6:0]};
					`MCL_OFF_MOT: s_axi_rdata <= {17'h0, mot[14:8], 1'b0, mot[6:0]};
					`MCL_OFF_FLT: s_axi_rdata <= {25'h0, oc_flag, fault_flags};
					`MCL_OFF_STS: s_axi_rdata <= {amp_out, 13'h0, state};
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= 2'h2;
					end
				endcase
			end
		end
	end
	assign s_axi_arready = !s_axi_rvalid;
endmodule

// *** tb/mcl_motor_model.sv ***
// motor and bridge model returning currents and tach
`timescale 1ns/1ps
module mcl_motor_model (
	// clock
	input wire logic aclk,
	// bridge state
	input wire logic lowside_all_on,
	input wire logic bridge_hiz,
	// load asked by the bench
	input wire mcl_pkg::mcl_meas_t want,
	// sensed values
	output mcl_pkg::mcl_meas_t meas,
	output logic fg_in
);
	logic [11:0] coil_ma = 12'h000;
	logic [2:0] div = 3'h0;
	logic fg_q = 1'b0;
	// winding current decays once the bridge stops driving
	always @(posedge aclk) begin
		if (lowside_all_on || bridge_hiz) begin
			coil_ma <= (coil_ma > 12'h064) ? coil_ma - 12'h064 : 12'h000;
		end else begin
			coil_ma <= want.phase_u_ma;
		end
		if (!bridge_hiz) begin
			div <= div + 3'h1;
			fg_q <= (div == 3'h7) ? !fg_q : fg_q;
		end
	end
	always_comb begin
		meas = want;
		meas.phase_u_ma = coil_ma;
		if (lowside_all_on || bridge_hiz) begin
			meas.lowside_ma = coil_ma;
		end
	end
	assign fg_in = fg_q;
endmodule

// *** tb/mcl_supervisor_properties.sv ***
// port assertions of the supervisor
`timescale 1ns/1ps
module mcl_supervisor_properties (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// watched inputs
	input wire mcl_pkg::mcl_meas_t meas,
	input wire mcl_pkg::mcl_events_t ev,
	input wire logic short_pin,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// bridge side
	input wire logic [15:0] amp_out,
	input wire logic bridge_hiz,
	input wire logic lowside_all_on,
	input wire logic restart,
	input wire logic speed_feedback_output
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic off;
	assign off = bridge_hiz || lowside_all_on;
	brake_excl_a: assert property (!(bridge_hiz && lowside_all_on))
		else $error("brake and hiz together");
	brake_first_a: assert property ($rose(bridge_hiz) |-> $past(lowside_all_on))
		else $error("hiz without brake");
	fb_locked_a: assert property (off |-> speed_feedback_output)
		else $error("feedback low while locked");
	amp_off_a: assert property (off && $past(off) |-> amp_out == 16'h0000)
		else $error("drive while off");
	restart_pulse_a: assert property (restart |=> !restart)
		else $error("restart too long");
	restart_src_a: assert property (restart |-> $past(bridge_hiz))
		else $error("restart without hiz");
	short_trip_a: assert property (short_pin [*3] |-> ##[0:3] off)
		else $error("short not tripped");
	amp_ceiling_a: assert property ($past(ce) |-> amp_out <= $past(meas.amp_cmd))
		else $error("amplitude above command");
	open_pass_a: assert property (ce && !ev.closed_loop && !off ##1 !off |->
		amp_out == $past(meas.amp_cmd))
		else $error("clamp outside closed loop");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	cover property (restart);
	cover property ($rose(lowside_all_on));
	cover property (ev.closed_loop && amp_out < meas.amp_cmd);
endmodule
bind mcl_supervisor mcl_supervisor_properties i_mcl_supervisor_properties (
	.aclk(aclk), .aresetn(aresetn), .ce(ce), .meas(meas), .ev(ev), .short_pin(short_pin),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.amp_out(amp_out), .bridge_hiz(bridge_hiz), .lowside_all_on(lowside_all_on),
	.restart(restart), .speed_feedback_output(speed_feedback_output));

// *** tb/test_motor_current_limit_lock_detect.sv ***
// self-checking bench of the supervisor
`timescale 1ns/1ps
`include "mcl_defs.svh"
module test_motor_current_limit_lock_detect;
	localparam int LOCK_OFF = 20;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, hiz, brake, restart, fb, fg;
	logic short_r = 1'b0;
	logic ce_r = 1'b1;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, q;
	logic [15:0] amp_out;
	mcl_pkg::mcl_meas_t want = '0;
	mcl_pkg::mcl_meas_t meas;
	mcl_pkg::mcl_events_t ev = '0;
	int bad_count = 0, checked = 0, n;
	always #2.5 aclk = !aclk;
	mcl_supervisor #(.LOCK_OFF_CYCLES(LOCK_OFF), .ERR_WIN_CYCLES(8), .KT_WIN_CYCLES(8),
		.BRAKE_CYCLES(4)) i_mcl_supervisor (.aclk(aclk), .aresetn(aresetn), .ce(ce_r),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.meas(meas), .ev(ev), .fg_in(fg), .short_pin(short_r), .amp_out(amp_out),
		.bridge_hiz(hiz), .lowside_all_on(brake), .restart(restart),
		.speed_feedback_output(fb));
	mcl_motor_model i_mcl_motor_model (.aclk(aclk), .lowside_all_on(brake), .bridge_hiz(hiz),
		.want(want), .meas(meas), .fg_in(fg));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		if (bad_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok, ar_ok, done;
		done = 1'b0;
		@(posedge aclk);
		if (wr) begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
		end else begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
		end
		while (!done) begin
			@(negedge aclk);
			aw_ok = awvalid && awready;
			w_ok = wvalid && wready;
			ar_ok = arvalid && arready;
			done = (wr ? bvalid : rvalid) === 1'b1;
			q = rdata;
			resp = wr ? bresp : rresp;
			@(posedge aclk);
			if (aw_ok) awvalid <= 1'b0;
			if (w_ok) wvalid <= 1'b0;
			if (ar_ok) arvalid <= 1'b0;
		end
		bready <= 1'b0;
		rready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] r);
		bus(1'b0, a, 32'h0);
		check("rdata", q & m, e);
		check("rresp", 32'(resp), 32'(r));
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		bus(1'b1, a, d);
		check("bresp", 32'(resp), 32'(r));
	endtask
	task automatic trip(input int kind, input logic [6:0] flag);
		if (kind == 0) want.lowside_ma <= 2 * `MCL_LCK_STEP_MA + 12'h001;
		if (kind == 1) want.phase_u_ma <= `MCL_NO_MOTOR_MA;
		if (kind == 2) short_r <= 1'b1;
		if (kind == 3) begin
			ev.closed_loop <= 1'b1;
			ev.commutate <= 1'b1;
			@(posedge aclk);
			ev.commutate <= 1'b0;
		end
		repeat (3) @(posedge aclk);
		ev.closed_loop <= 1'b0;
		ev.ol_to_cl <= kind == 1;
		@(posedge aclk);
		ev.ol_to_cl <= 1'b0;
		short_r <= 1'b0;
		want.lowside_ma <= 12'h000;
		want.phase_u_ma <= 12'h1F4;
		while (brake !== 1'b1) @(negedge aclk);
		check("feedback", 32'(fb), 32'h1);
		rd(`MCL_OFF_FLT, {25'h0, flag}, {25'h0, flag}, 2'h0);
		while (hiz !== 1'b1) @(negedge aclk);
		n = 0;
		while (restart !== 1'b1) begin
			@(negedge aclk);
			n++;
		end
		check("off time", 32'(n >= LOCK_OFF - 1 && n <= LOCK_OFF + 1), 32'h1);
		rd(`MCL_OFF_FLT, 32'h3F, 32'h0, 2'h0);
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		want.phase_u_ma <= 12'h1F4;
		want.amp_cmd <= 16'h03E8;
		rd(`MCL_OFF_CFG, 32'hFFFFFFFF, `MCL_CFG_RESET, 2'h0);
		rd(`MCL_OFF_MOT, 32'hFFFFFFFF, `MCL_MOT_RESET, 2'h0);
		rd(`MCL_OFF_FLT, 32'hFFFFFFFF, 32'h0, 2'h0);
		rd(8'h10, 32'hFFFFFFFF, 32'h0, 2'h2);
		wr(`MCL_OFF_FLT, 32'h3F, 2'h2);
		wr(`MCL_OFF_MOT, 32'h0000000F, 2'h0);
		rd(`MCL_OFF_MOT, 32'hFFFFFFFF, 32'h0000000F, 2'h0);
		for (int s = 0; s < 16; s += 5) begin
			wr(`MCL_OFF_CFG, s, 2'h0);
			ev.closed_loop <= 1'b0;
			repeat (4) @(posedge aclk);
			check("open amp", 32'(amp_out), 32'h3E8);
			ev.closed_loop <= 1'b1;
			repeat (4) @(posedge aclk);
			check("clamp amp", 32'(amp_out), ((s + 1) * `MCL_ACC_STEP_MA * 15) >> 10);
			check("no trip", 32'(brake || hiz), 32'h0);
		end
		rd(`MCL_OFF_STS, 32'hFFFF0000, 32'h002E0000, 2'h0);
		want.amp_cmd <= 16'h0001;
		ce_r <= 1'b0;
		repeat (3) @(posedge aclk);
		check("frozen amp", 32'(amp_out), 32'h2E);
		ce_r <= 1'b1;
		want.amp_cmd <= 16'h03E8;
		@(posedge aclk);
		ev.closed_loop <= 1'b0;
		wr(`MCL_OFF_CFG, 32'h00003E10, 2'h0);
		want.lowside_ma <= 2 * `MCL_LCK_STEP_MA;
		rd(`MCL_OFF_FLT, 32'h1, 32'h0, 2'h0);
		want.lowside_ma <= 2 * `MCL_LCK_STEP_MA + 12'h001;
		@(posedge aclk);
		want.lowside_ma <= 12'h000;
		repeat (3) @(posedge aclk);
		check("masked trip", 32'(brake || hiz), 32'h0);
		rd(`MCL_OFF_FLT, 32'h1, 32'h1, 2'h0);
		wr(`MCL_OFF_CFG, 32'h00003F10, 2'h0);
		trip(0, 7'h01);
		trip(1, 7'h08);
		trip(3, 7'h20);
		wr(`MCL_OFF_CFG, 32'h00000010, 2'h0);
		trip(2, 7'h40);
		finish_test();
	end
	initial begin
		#50000;
		bad_count++;
		finish_test();
	end
endmodule
